// file: dld_defs.svh
/*
 Module layout descriptor constants: offsets, field positions, reset values.
 Assumes inclusion by bare name from design files.
*/
`ifndef DLD_DEFS_SVH
`define DLD_DEFS_SVH
`define DLD_OFS_SLOT0 8'h48
`define DLD_OFS_SLOT1 8'h4C
`define DLD_OFS_SLOT2 8'h50
`define DLD_DEV_CH0 5'h04
`define DLD_DEV_CH1 5'h05
`define DLD_FUNC 3'h1
`define DLD_RESET 13'h0000
`define DLD_RANK_HI 12
`define DLD_RANK_LO 10
`define DLD_POP_BIT 9
`define DLD_BANK_HI 8
`define DLD_BANK_LO 7
`define DLD_RNK_HI 6
`define DLD_RNK_LO 5
`define DLD_ROW_HI 4
`define DLD_ROW_LO 2
`define DLD_COL_HI 1
`define DLD_COL_LO 0
`define DLD_ROW_MAX 3'h4
`define DLD_COL_RSVD 2'h3
`define DLD_CNT_RSVD 2'h3
`endif

// file: dld_pkg.sv
/*
 Types for the module layout descriptor bank.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package dld_pkg;
  typedef struct packed {
    logic [2:0] first_rank_offset;
    logic slot_populated;
    logic [1:0] bank_count_code;
    logic [1:0] rank_count_code;
    logic [2:0] row_count_code;
    logic [1:0] column_count_code;
  } dld_desc_t;
  typedef enum logic [1:0] {
    DLD_IDLE = 2'b00,
    DLD_RESP = 2'b01
  } dld_state_t;
endpackage

// file: dld_if.sv
/*
 Carrier between the decoder and the descriptor storage.
 Assumes one clock domain.
*/
`timescale 1ns/1ns
interface dld_if;
  logic wr;
  logic [2:0] sel;
  logic [12:0] wdata;
  logic [12:0] rdata [0:2];
  modport ctrl (output wr, output sel, output wdata, input rdata);
  modport store (input wr, input sel, input wdata, output rdata);
endinterface

// file: dld_slot_store.sv
/*
 Three slot descriptors of one channel, held in flip-flops.
 Assumes writes already decoded to a one-hot slot select.
*/
`timescale 1ns/1ns
`include "dld_defs.svh"
module dld_slot_store (
  input wire logic mclk,
  input wire logic rst,
  dld_if.store bus
);
  logic [12:0] desc_q [0:2];
  genvar i;
  generate
    for (i = 0; i < 3; i++) begin : g_slot
      always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
          desc_q[i] <= `DLD_RESET;
        end else if (bus.wr && bus.sel[i]) begin
          desc_q[i] <= bus.wdata;
        end
      end
      assign bus.rdata[i] = desc_q[i];
    end
  endgenerate
endmodule

// file: dld_bank.sv
/*
 Module layout descriptor bank for two memory channels, three slots each.
 Assumes a dword configuration port: one-cycle request strobe with device,
 function and dword offset; answers one cycle later with a done pulse.
*/
// Contract
// - First-rank offset field in bits 12:10
// - Bit 9 flags slot populated
// - Bits 8:7 encode bank count
// - Bits 6:5 encode rank count
// - Bits 4:2 encode row exponent
// - Bits 1:0 column count, 11 reserved
// - Offsets 48h,4Ch,50h on devices 4,5
`timescale 1ns/1ns
`include "dld_defs.svh"
module dld_bank (
  input wire logic mclk,
  input wire logic rst,
  input wire logic cfg_req,
  input wire logic cfg_write,
  input wire logic [4:0] cfg_device,
  input wire logic [2:0] cfg_function,
  input wire logic [7:0] cfg_offset,
  input wire logic [31:0] cfg_wdata,
  output logic cfg_done,
  output logic cfg_hit,
  output logic [31:0] cfg_rdata,
  output dld_pkg::dld_desc_t ch0_slot [0:2],
  output dld_pkg::dld_desc_t ch1_slot [0:2],
  output logic [5:0] layout_bad
);
  dld_if ch0_if ();
  dld_if ch1_if ();

  function automatic logic [2:0] slot_decode(input logic [7:0] ofs);
    logic [2:0] s;
    s = 3'b000;
    if (ofs == `DLD_OFS_SLOT0) begin
      s = 3'b001;
    end else if (ofs == `DLD_OFS_SLOT1) begin
      s = 3'b010;
    end else if (ofs == `DLD_OFS_SLOT2) begin
      s = 3'b100;
    end
    return s;
  endfunction

  function automatic logic bank_code_rsvd(input logic [12:0] d);
    return d[`DLD_BANK_HI:`DLD_BANK_LO] == `DLD_CNT_RSVD;
  endfunction

  function automatic logic rank_code_rsvd(input logic [12:0] d);
    return d[`DLD_RNK_HI:`DLD_RNK_LO] == `DLD_CNT_RSVD;
  endfunction

  function automatic logic row_code_rsvd(input logic [12:0] d);
    return d[`DLD_ROW_HI:`DLD_ROW_LO] > `DLD_ROW_MAX;
  endfunction

  function automatic logic col_code_rsvd(input logic [12:0] d);
    return d[`DLD_COL_HI:`DLD_COL_LO] == `DLD_COL_RSVD;
  endfunction

  // Reserved codes in any count field mark the layout unusable
  function automatic logic desc_bad(input logic [12:0] d);
    return bank_code_rsvd(d) || rank_code_rsvd(d) || row_code_rsvd(d) || col_code_rsvd(d);
  endfunction

  // Only populated slots count; stale codes in an empty slot are harmless
  function automatic logic slot_flag(input logic [12:0] d);
    return d[`DLD_POP_BIT] && desc_bad(d);
  endfunction

  // Zero on no match, though the hit gate masks that case anyway
  function automatic logic [12:0] slot_pick(input logic [2:0] sel, input logic [12:0] d0,
    input logic [12:0] d1, input logic [12:0] d2);
    logic [12:0] r;
    r = 13'h0000;
    if (sel[0]) begin
      r = d0;
    end else if (sel[1]) begin
      r = d1;
    end else if (sel[2]) begin
      r = d2;
    end
    return r;
  endfunction

  wire logic fn_ok = (cfg_function == `DLD_FUNC);
  wire logic ch0_sel = fn_ok && (cfg_device == `DLD_DEV_CH0);
  wire logic ch1_sel = fn_ok && (cfg_device == `DLD_DEV_CH1);
  wire logic [2:0] slot_sel = slot_decode(cfg_offset);
  wire logic hit = (ch0_sel || ch1_sel) && (slot_sel != 3'b000);
  wire logic do_write = cfg_req && cfg_write && hit;
  wire logic do_read = cfg_req && !cfg_write;

  assign ch0_if.wr = do_write && ch0_sel;
  assign ch0_if.sel = slot_sel;
  assign ch0_if.wdata = cfg_wdata[12:0];
  assign ch1_if.wr = do_write && ch1_sel;
  assign ch1_if.sel = slot_sel;
  assign ch1_if.wdata = cfg_wdata[12:0];

  dld_slot_store u_ch0 (.mclk(mclk), .rst(rst), .bus(ch0_if.store));
  dld_slot_store u_ch1 (.mclk(mclk), .rst(rst), .bus(ch1_if.store));

  wire logic [12:0] ch0_pick = slot_pick(slot_sel, ch0_if.rdata[0], ch0_if.rdata[1], ch0_if.rdata[2]);
  wire logic [12:0] ch1_pick = slot_pick(slot_sel, ch1_if.rdata[0], ch1_if.rdata[1], ch1_if.rdata[2]);
  wire logic [31:0] rd_word = !hit ? 32'h0000_0000 :
                              ch0_sel ? {19'h0_0000, ch0_pick} : {19'h0_0000, ch1_pick};

  dld_pkg::dld_state_t state_q;
  dld_pkg::dld_state_t state_d;
  always_comb begin
    case (state_q)
      dld_pkg::DLD_IDLE: state_d = cfg_req ? dld_pkg::DLD_RESP : dld_pkg::DLD_IDLE;
      dld_pkg::DLD_RESP: state_d = cfg_req ? dld_pkg::DLD_RESP : dld_pkg::DLD_IDLE;
      default: state_d = dld_pkg::DLD_IDLE;
    endcase
  end

  // Next values of the answer registers; read data stays zero outside a read answer
  wire logic done_d = (state_d == dld_pkg::DLD_RESP);
  wire logic hit_d = cfg_req && hit;
  wire logic [31:0] rdata_d = do_read ? rd_word : 32'h0000_0000;

  // Answer in flight; back-to-back requests stay in the answer state
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_q <= dld_pkg::DLD_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Done follows every request, mapped or not
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cfg_done <= 1'b0;
    end else begin
      cfg_done <= done_d;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cfg_hit <= 1'b0;
    end else begin
      cfg_hit <= hit_d;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cfg_rdata <= 32'h0000_0000;
    end else begin
      cfg_rdata <= rdata_d;
    end
  end

  // Registered field view for the mapping logic
  // rank offset bits 12:10
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      for (int k = 0; k < 3; k++) begin
        ch0_slot[k] <= dld_pkg::dld_desc_t'(`DLD_RESET);
      end
    end else begin
      for (int k = 0; k < 3; k++) begin
        ch0_slot[k] <= dld_pkg::dld_desc_t'(ch0_if.rdata[k]);
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      for (int k = 0; k < 3; k++) begin
        ch1_slot[k] <= dld_pkg::dld_desc_t'(`DLD_RESET);
      end
    end else begin
      for (int k = 0; k < 3; k++) begin
        ch1_slot[k] <= dld_pkg::dld_desc_t'(ch1_if.rdata[k]);
      end
    end
  end

  // Bit s for channel 0, bit s+3 for channel 1
  wire logic [5:0] bad_d;
  genvar s;
  generate
    for (s = 0; s < 3; s++) begin : g_bad
      assign bad_d[s] = slot_flag(ch0_if.rdata[s]);
      assign bad_d[s+3] = slot_flag(ch1_if.rdata[s]);
    end
  endgenerate

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      layout_bad <= 6'h00;
    end else begin
      layout_bad <= bad_d;
    end
  end

  // offsets are software's duty; stored as written
  // No mode bit says how many modules sit on a channel, so nothing could check them
endmodule

// file: dld_bank_assertions.sv
/* Checker for the dld_bank configuration port.
   Assumes a bind to dld_bank and one clock domain. */
`timescale 1ns/1ns
module dld_bank_assertions (
  input wire logic mclk,
  input wire logic rst,
  input wire logic cfg_req,
  input wire logic cfg_write,
  input wire logic [4:0] cfg_device,
  input wire logic [2:0] cfg_function,
  input wire logic [7:0] cfg_offset,
  input wire logic [31:0] cfg_wdata,
  input wire logic cfg_done,
  input wire logic cfg_hit,
  input wire logic [31:0] cfg_rdata
);
  wire map_w = cfg_device inside {5'h04, 5'h05} && cfg_function == 3'h1 && cfg_offset inside {8'h48, 8'h4C, 8'h50};
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  sequence wr_s; cfg_req && cfg_write && map_w; endsequence
  sequence rd_s; cfg_req && !cfg_write && map_w && cfg_offset == $past(cfg_offset, 2)
    && cfg_device == $past(cfg_device, 2); endsequence
  AST_DONE: assert property (cfg_req |=> cfg_done) else $error("no done");
  AST_NODONE: assert property (!cfg_req |=> !cfg_done) else $error("stray done");
  AST_HIT: assert property (cfg_req && map_w |=> cfg_hit) else $error("no hit");
  AST_MISS: assert property (cfg_req && !map_w |=> !cfg_hit && cfg_rdata == 32'h0) else $error("miss");
  AST_HI0: assert property (cfg_rdata[31:13] == 19'h0) else $error("high bits");
  AST_IDLE0: assert property (!cfg_done |-> cfg_rdata == 32'h0) else $error("idle rdata");
  AST_HITDONE: assert property (cfg_hit |-> cfg_done) else $error("hit alone");
  AST_RDBACK: assert property (wr_s ##1 !cfg_req ##1 rd_s |=> cfg_rdata[12:0] == $past(cfg_wdata[12:0], 3))
    else $error("readback");
endmodule
bind dld_bank dld_bank_assertions chk_u (.mclk, .rst, .cfg_req, .cfg_write, .cfg_device, .cfg_function,
  .cfg_offset, .cfg_wdata, .cfg_done, .cfg_hit, .cfg_rdata);

// file: dld_bank_bench.sv
/* Bench for dld_bank: write/read rows, then reset and refusal cases.
   Assumes dld_pkg, dld_if, dld_slot_store and dld_bank compiled first. */
`timescale 1ns/1ns
module dld_bank_bench;
  logic mclk = 0, rst = 1, cfg_req = 0, cfg_write = 0, cfg_done, cfg_hit;
  logic [4:0] cfg_device = 5'h04;
  logic [2:0] cfg_function = 3'h1;
  logic [7:0] cfg_offset = 8'h48;
  logic [31:0] cfg_wdata = 32'h0, cfg_rdata;
  logic [5:0] layout_bad;
  dld_pkg::dld_desc_t ch0_slot [0:2], ch1_slot [0:2];
  int mismatches = 0, checks_done = 0, s;
  // Device, offset, write data; high junk must be dropped
  // Channel 0 carries three modules (offsets 0, 2, 4), channel 1 two (0, 4)
  logic [44:0] rows [0:5] = '{{5'h04, 8'h48, 32'hFFFF_E200}, {5'h04, 8'h4C, 32'h0000_0AA5},
    {5'h04, 8'h50, 32'h0000_134A}, {5'h05, 8'h48, 32'h0000_028C}, {5'h05, 8'h4C, 32'h0000_1232},
    {5'h05, 8'h50, 32'h8000_1000}};
  dld_bank dut_u (.mclk, .rst, .cfg_req, .cfg_write, .cfg_device, .cfg_function, .cfg_offset,
    .cfg_wdata, .cfg_done, .cfg_hit, .cfg_rdata, .ch0_slot, .ch1_slot, .layout_bad);
  always #50 mclk = ~mclk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Answer is fixed at one cycle, so no wait loop is needed
  task automatic acc(input logic w, input logic [4:0] d, input logic [2:0] f, input logic [7:0] o,
    input logic [31:0] v);
    @(posedge mclk) #1;
    {cfg_req, cfg_write, cfg_device, cfg_function, cfg_offset, cfg_wdata} = {1'b1, w, d, f, o, v};
    @(posedge mclk) #1;
    cfg_req = 0;
  endtask
  task automatic rd(input logic [4:0] d, input logic [2:0] f, input logic [7:0] o,
    input logic [31:0] e, input logic h);
    acc(1'b0, d, f, o, 32'h0);
    chk({31'h0, cfg_done}, 32'h1);
    chk({31'h0, cfg_hit}, {31'h0, h});
    chk(cfg_rdata, e);
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge mclk);
    #1 rst = 0;
    for (int i = 0; i < 6; i++) rd(rows[i][44:40], 3'h1, rows[i][39:32], 32'h0, 1'b1);
    $display("reset values done");
    // Rows hold offsets 0, 2 or 4, 4 and every non-reserved field code
    for (int i = 0; i < 6; i++) begin
      acc(1'b1, rows[i][44:40], 3'h1, rows[i][39:32], rows[i][31:0]);
      rd(rows[i][44:40], 3'h1, rows[i][39:32], {19'h0, rows[i][12:0]}, 1'b1);
      s = (rows[i][39:32] - 8'h48) >> 2;
      chk({19'h0, rows[i][44:40] == 5'h04 ? ch0_slot[s] : ch1_slot[s]}, {19'h0, rows[i][12:0]});
    end
    chk({26'h0, layout_bad}, 32'h0);
    $display("table done");
    acc(1'b1, 5'h04, 3'h0, 8'h48, 32'h1FFF);
    rd(5'h06, 3'h1, 8'h48, 32'h0, 1'b0);
    rd(5'h04, 3'h1, 8'h54, 32'h0, 1'b0);
    chk({19'h0, ch0_slot[0]}, 32'h0000_0200);
    $display("unmapped done");
    acc(1'b1, 5'h05, 3'h1, 8'h50, 32'h0000_1203);
    repeat (2) @(posedge mclk) #1;
    chk({26'h0, layout_bad}, 32'h20);
    acc(1'b1, 5'h04, 3'h1, 8'h4C, 32'h0000_0B80);
    acc(1'b1, 5'h04, 3'h1, 8'h50, 32'h0000_1214);
    acc(1'b1, 5'h05, 3'h1, 8'h48, 32'h0000_0260);
    acc(1'b1, 5'h05, 3'h1, 8'h4C, 32'h0000_1003);
    repeat (2) @(posedge mclk) #1;
    chk({26'h0, layout_bad}, 32'h2E);
    $display("reserved code done");
    rst = 1;
    @(posedge mclk) #1 rst = 0;
    chk({26'h0, layout_bad}, 32'h0);
    chk({19'h0, ch1_slot[2]}, 32'h0);
    rd(5'h04, 3'h1, 8'h4C, 32'h0, 1'b1);
    $display("mid-run reset done");
    print_verdict;
  end
endmodule
